// ===== fbo_pkg.sv
// Functional notes
// - hardware reset clears output register; soft reset keeps
// - output register read/write, writable during soft reset
// - four-drive: encoded select, motor zero low if enabled
// - four-drive, motor off: select driven, motor zero high
// - four-drive: motor one pulses with every offset-2 write
// - select bits assert at most one drive select
// - bit 2 low holds controller core in reset
// - soft reset restores configure/mode settings only
// - legacy mode: bit 3 gates dack, tc, drq, irq
// - alternate mode: dma signals always enabled
// - two-drive: bits 4,5 drive motors zero, one
// - bit 6 drives motor two when exchanged/four-drive
// - at-compatible mode: tape register bits 7-2 float
// - tape register names the tape-support logical drive
// - tape bits 1,0: 00 none, else drives 1-3
package fbo_pkg;
	// register offsets on the three address pins
	localparam logic [2:0] OFS_DRIVE_OUTPUT_CONTROL = 3'h2;
	localparam logic [2:0] OFS_TAPE_MEDIA_DRIVE_TYPE = 3'h3;
	// drive output control field positions
	localparam int DOC_SEL_LSB = 0;
	localparam int DOC_RUN_BIT = 2;
	localparam int DOC_DMA_BIT = 3;
	localparam int DOC_MOTOR_LSB = 4;
	// values after hardware reset
	localparam logic [7:0] RST_DRIVE_OUTPUT_CONTROL = 8'h00;
	localparam logic [1:0] RST_TAPE_SELECT = 2'h0;
	localparam logic [1:0] RST_PINS_N = 2'h3;
	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;
	// least low time of the reset bit, kept by software
	localparam int SOFT_RESET_LOW_NS = 100;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SOFT_RESET_LOW_CYC =
		(SOFT_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// width of the synchronised host bundle: cs, rd, wr, addr, data
	localparam int HOST_W = 14;
endpackage

// ===== fbo_sync.sv
`timescale 1ns/10ps
module fbo_sync
	import fbo_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// asynchronous level in, synchronised level out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fbo_sync_t;

	fbo_sync_t st_ff;
	fbo_sync_t nxt_st;

	// first stage feeds only the second stage
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = async_i;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= {RST, RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_o = st_ff.s2;
endmodule

// ===== fbo_drive_output.sv
`timescale 1ns/10ps
module fbo_drive_output
	import fbo_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// host register port (pins)
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic [7:0] data_oe_n_o,
	// configuration from same-clock logic
	input wire logic fdc_enable_i,
	input wire logic four_drive_i,
	input wire logic exchange_0_2_i,
	input wire logic alt_system_mode_i,
	input wire logic tape_enhanced_mode_i,
	// drive interface pins
	output logic [1:0] drive_sel_n_o,
	output logic motor_out_zero_o,
	output logic motor_out_one_o,
	// controller core side
	output logic core_soft_reset_o,
	output logic [1:0] tape_drive_num_o,
	output logic tape_drive_selected_o,
	// dma and interrupt gating
	input wire logic dack_n_i,
	input wire logic tc_i,
	input wire logic drq_core_i,
	input wire logic irq_core_i,
	output logic dack_n_o,
	output logic tc_o,
	output logic drq_o,
	output logic drq_oe_n_o,
	output logic irq_o,
	output logic irq_oe_n_o
);
	typedef struct packed {
		logic [7:0] doc;
		logic [1:0] tape_sel;
		logic wr_n_prev;
		logic [7:0] rd_data;
		logic [7:0] rd_oe_n;
		logic [1:0] sel_n;
		logic [1:0] mtr_n;
	} fbo_state_t;

	fbo_state_t st_ff;
	fbo_state_t nxt_st;

	logic [HOST_W-1:0] host_s;
	logic s_cs_n;
	logic s_rd_n;
	logic s_wr_n;
	logic [2:0] s_addr;
	logic [7:0] s_data;
	logic wr_lead;
	logic wr_hit_doc;
	logic wr_hit_tape;
	logic wr_active_doc;
	logic dma_gate;

	// motor enable bit for a selected drive number
	function automatic logic motor_of(input logic [7:0] doc,
			input logic [1:0] sel);
		motor_of = doc[DOC_MOTOR_LSB + int'(sel)];
	endfunction

	// bus pins come from the host clock domain
	fbo_sync #(
		.W(HOST_W),
		.RST({3'h7, 3'h0, 8'h00})
	) u_host_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.async_i({cs_n_i, rd_n_i, wr_n_i, addr_i, data_i}),
		.sync_o(host_s)
	);

	assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_data} = host_s;

	// a write lands once, on the leading edge of the strobe
	assign wr_lead = !s_wr_n && st_ff.wr_n_prev && !s_cs_n;
	assign wr_hit_doc = wr_lead && (s_addr == OFS_DRIVE_OUTPUT_CONTROL);
	assign wr_hit_tape = wr_lead && (s_addr == OFS_TAPE_MEDIA_DRIVE_TYPE);
	// strobe level for the external latch clock
	assign wr_active_doc = !s_wr_n && !s_cs_n &&
		(s_addr == OFS_DRIVE_OUTPUT_CONTROL);

	// next state: registers, read data and pin images
	always_comb begin
		nxt_st = st_ff;
		nxt_st.wr_n_prev = s_wr_n;
		// no soft-reset term here: writes always land
		if (wr_hit_doc) begin
			nxt_st.doc = s_data;
		end
		if (wr_hit_tape) begin
			nxt_st.tape_sel = s_data[1:0];
		end
		// reads answer only our two offsets; others leave the bus alone
		nxt_st.rd_data = 8'h00;
		nxt_st.rd_oe_n = 8'hff;
		if (!s_cs_n && !s_rd_n) begin
			if (s_addr == OFS_DRIVE_OUTPUT_CONTROL) begin
				nxt_st.rd_data = st_ff.doc;
				nxt_st.rd_oe_n = 8'h00;
			end else if (s_addr == OFS_TAPE_MEDIA_DRIVE_TYPE) begin
				nxt_st.rd_data = {6'h00, st_ff.tape_sel};
				// upper bits float in at-compatible mode
				nxt_st.rd_oe_n = tape_enhanced_mode_i ? 8'h00 : 8'hfc;
			end
		end
		// drive and motor pins, low-active except the latch strobe and the encoded select
		nxt_st.sel_n = RST_PINS_N;
		nxt_st.mtr_n = RST_PINS_N;
		if (fdc_enable_i && four_drive_i) begin
			// encoded select for the external latch
			nxt_st.sel_n = st_ff.doc[DOC_SEL_LSB+:2];
			// motor zero carries the selected motor
			nxt_st.mtr_n[0] = !motor_of(st_ff.doc,
				st_ff.doc[DOC_SEL_LSB+:2]);
			// high while the write strobe is low
			nxt_st.mtr_n[1] = wr_active_doc;
		end else if (fdc_enable_i) begin
			// direct selects, one at most, no strobe
			nxt_st.sel_n[0] = !(st_ff.doc[DOC_SEL_LSB+:2] ==
				(exchange_0_2_i ? 2'h2 : 2'h0));
			nxt_st.sel_n[1] = !(st_ff.doc[DOC_SEL_LSB+:2] == 2'h1);
			// exchanged drive two takes pin zero
			nxt_st.mtr_n[0] = !(exchange_0_2_i ?
				st_ff.doc[DOC_MOTOR_LSB+2] : st_ff.doc[DOC_MOTOR_LSB]);
			nxt_st.mtr_n[1] = !st_ff.doc[DOC_MOTOR_LSB+1];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff.doc <= RST_DRIVE_OUTPUT_CONTROL;
			st_ff.tape_sel <= RST_TAPE_SELECT;
			st_ff.wr_n_prev <= 1'b1;
			st_ff.rd_data <= 8'h00;
			st_ff.rd_oe_n <= 8'hff;
			st_ff.sel_n <= RST_PINS_N;
			st_ff.mtr_n <= RST_PINS_N;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// host data bus
	assign data_o = st_ff.rd_data;
	assign data_oe_n_o = st_ff.rd_oe_n;

	// drive pins
	assign drive_sel_n_o = st_ff.sel_n;
	assign motor_out_zero_o = st_ff.mtr_n[0];
	assign motor_out_one_o = st_ff.mtr_n[1];

	// core held in reset while the run bit is low; the core restores
	// its configure and mode settings, this register stays
	assign core_soft_reset_o = !st_ff.doc[DOC_RUN_BIT];

	// tape support goes to one logical drive, never drive 0
	assign tape_drive_num_o = st_ff.tape_sel;
	assign tape_drive_selected_o = (st_ff.tape_sel != 2'h0) &&
		(st_ff.tape_sel == st_ff.doc[DOC_SEL_LSB+:2]);

	// alternate mode ignores the enable bit, even in reset
	assign dma_gate = alt_system_mode_i || st_ff.doc[DOC_DMA_BIT];
	// legacy mode gates the lines by the enable bit
	assign dack_n_o = dack_n_i || !dma_gate;
	assign tc_o = tc_i && dma_gate;
	assign drq_o = drq_core_i;
	assign drq_oe_n_o = !dma_gate;
	assign irq_o = irq_core_i;
	assign irq_oe_n_o = !dma_gate;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_hw_reset_clear: assert property (
		disable iff (1'b0) !rstn_i |-> st_ff.doc == 8'h00)
		else $error("output register not cleared in reset");

	a_doc_holds: assert property (!wr_hit_doc |=> $stable(st_ff.doc))
		else $error("output register changed without write");

	a_doc_write_lands: assert property (
		wr_hit_doc |=> st_ff.doc == $past(s_data))
		else $error("output register write lost");

	a_soft_reset: assert property (
		wr_hit_doc && !s_data[2] |=> core_soft_reset_o [*2])
		else $error("soft reset not held after clearing bit 2");

	a_enc_select: assert property (
		fdc_enable_i && four_drive_i |=>
			drive_sel_n_o == $past(st_ff.doc[1:0]))
		else $error("encoded select wrong");

	a_enc_motor: assert property (
		fdc_enable_i && four_drive_i |=> motor_out_zero_o ==
			!motor_of($past(st_ff.doc), $past(st_ff.doc[1:0])))
		else $error("encoded motor wrong");

	a_strobe_pulse: assert property (
		fdc_enable_i && four_drive_i && wr_active_doc |=> motor_out_one_o)
		else $error("latch strobe missing on write");

	a_two_motor: assert property (
		fdc_enable_i && !four_drive_i && !exchange_0_2_i |=>
			{motor_out_one_o, motor_out_zero_o} == ~$past(st_ff.doc[5:4]))
		else $error("two-drive motor pins wrong");

	a_one_select: assert property (
		fdc_enable_i && !four_drive_i |=> $countones(~drive_sel_n_o) <= 1)
		else $error("more than one drive selected");

	a_legacy_gate: assert property (
		!alt_system_mode_i && !st_ff.doc[3] |-> drq_oe_n_o && irq_oe_n_o
			&& dack_n_o && !tc_o)
		else $error("dma lines not gated off");

	a_alt_enabled: assert property (
		alt_system_mode_i |-> !drq_oe_n_o && !irq_oe_n_o)
		else $error("dma lines gated in alternate mode");

	a_tape_float: assert property (
		!s_cs_n && !s_rd_n && s_addr == OFS_TAPE_MEDIA_DRIVE_TYPE &&
			!tape_enhanced_mode_i |=> data_oe_n_o[7:2] == 6'h3f)
		else $error("tape register upper bits driven");

	a_tape_enh_read: assert property (
		!s_cs_n && !s_rd_n && s_addr == OFS_TAPE_MEDIA_DRIVE_TYPE &&
			tape_enhanced_mode_i |=> data_oe_n_o == 8'h00 &&
			data_o[7:2] == 6'h00)
		else $error("tape register enhanced read wrong");

	a_exch_motor: assert property (
		fdc_enable_i && !four_drive_i && exchange_0_2_i |=>
			motor_out_zero_o == !$past(st_ff.doc[6]))
		else $error("exchanged motor pin wrong");

	a_exch_select: assert property (
		fdc_enable_i && !four_drive_i && exchange_0_2_i |=>
			drive_sel_n_o[0] == ($past(st_ff.doc[1:0]) != 2'h2))
		else $error("exchanged select pin wrong");

	// a direct select pin is low only for its own drive number
	a_direct_select: assert property (
		fdc_enable_i && !four_drive_i && !exchange_0_2_i |=>
			drive_sel_n_o == {($past(st_ff.doc[1:0]) != 2'h1),
			($past(st_ff.doc[1:0]) != 2'h0)})
		else $error("direct select pins wrong");

	a_disabled_idle: assert property (
		!fdc_enable_i |=> drive_sel_n_o == 2'h3 && motor_out_zero_o &&
			motor_out_one_o)
		else $error("drive pins active while disabled");

	a_legacy_open: assert property (
		!alt_system_mode_i && st_ff.doc[3] |-> !drq_oe_n_o && !irq_oe_n_o
			&& dack_n_o == dack_n_i && tc_o == tc_i)
		else $error("dma lines not passed when enabled");

	a_tape_write: assert property (
		wr_hit_tape |=> tape_drive_num_o == $past(s_data[1:0]))
		else $error("tape select write lost");

	a_tape_not_zero: assert property (
		tape_drive_num_o == 2'h0 |-> !tape_drive_selected_o)
		else $error("tape drive flagged with no tape number");

	a_run_release: assert property (
		wr_hit_doc && s_data[2] |=> !core_soft_reset_o)
		else $error("soft reset not released after setting bit 2");

	c_exchange: cover property (fdc_enable_i && exchange_0_2_i &&
		wr_hit_doc);
	c_soft_toggle: cover property (wr_hit_doc && !s_data[DOC_RUN_BIT]);
	c_drive0_on: cover property (wr_hit_doc && s_data == 8'h1c);
	c_four_strobe: cover property (fdc_enable_i && four_drive_i &&
		wr_hit_doc ##1 motor_out_one_o);
	c_tape_read: cover property (!s_cs_n && !s_rd_n &&
		s_addr == OFS_TAPE_MEDIA_DRIVE_TYPE);
endmodule

// ===== fbo_drive_model.sv
`timescale 1ns/10ps
module fbo_drive_model (
	// pins from the controller
	input wire logic four_drive_i,
	input wire logic [1:0] drive_sel_n_i,
	input wire logic motor_out_zero_i,
	input wire logic motor_out_one_i,
	// decoded enables seen by the drives, active high
	output logic [3:0] drive_on_o,
	output logic [3:0] motor_on_o
);
	logic [2:0] held_ff = 3'h7;
	// board latch on the trailing strobe edge: select pins settle one
	// cycle after the strobe rises, so the leading edge would be stale
	always @(negedge motor_out_one_i) begin
		held_ff <= {motor_out_zero_i, drive_sel_n_i};
	end
	// every latched code is a defined row, so only one drive wakes
	always_comb begin
		drive_on_o = 4'h0;
		motor_on_o = 4'h0;
		if (four_drive_i) begin
			drive_on_o[held_ff[1:0]] = 1'b1;
			motor_on_o[held_ff[1:0]] = ~held_ff[2];
		end else begin
			drive_on_o = {2'h0, ~drive_sel_n_i};
			motor_on_o = {2'h0, ~motor_out_one_i, ~motor_out_zero_i};
		end
	end
endmodule

// ===== fbo_tb.sv
`timescale 1ns/10ps
module testbench;
	import fbo_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b1;
	logic cs_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] data_i = 8'h00, got_d, got_oe, data_o, data_oe_n_o, v;
	logic en_i = 1'b1, four_i = 1'b0, alt_i = 1'b0, tape_i = 1'b0;
	logic xch_i = 1'b0;
	logic dack_n_i = 1'b0, tc_i = 1'b1, drq_i = 1'b1, irq_i = 1'b1;
	logic [1:0] sel_n, tape_num;
	logic m0, m1, core_rst, tape_sel, dack_n_o, tc_o, drq_o, drq_oe_n;
	logic irq_o, irq_oe_n;
	logic [3:0] drive_on, motor_on;
	int bad_count = 0, tests_run = 0, cycles = 0;

	fbo_drive_output DUT (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
		.rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i),
		.data_o(data_o), .data_oe_n_o(data_oe_n_o), .fdc_enable_i(en_i),
		.four_drive_i(four_i), .exchange_0_2_i(xch_i),
		.alt_system_mode_i(alt_i), .tape_enhanced_mode_i(tape_i),
		.drive_sel_n_o(sel_n), .motor_out_zero_o(m0),
		.motor_out_one_o(m1), .core_soft_reset_o(core_rst),
		.tape_drive_num_o(tape_num), .tape_drive_selected_o(tape_sel),
		.dack_n_i(dack_n_i), .tc_i(tc_i), .drq_core_i(drq_i),
		.irq_core_i(irq_i), .dack_n_o(dack_n_o), .tc_o(tc_o),
		.drq_o(drq_o), .drq_oe_n_o(drq_oe_n), .irq_o(irq_o),
		.irq_oe_n_o(irq_oe_n));
	fbo_drive_model drives (.four_drive_i(four_i), .drive_sel_n_i(sel_n),
		.motor_out_zero_i(m0), .motor_out_one_i(m1),
		.drive_on_o(drive_on), .motor_on_o(motor_on));

	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	// address and data settle three cycles ahead of the strobes
	task automatic bus(input logic wr, input logic [2:0] a,
			input logic [7:0] d);
		addr_i = a;
		data_i = d;
		repeat (3) @(negedge clk_i);
		cs_n_i = 1'b0;
		wr_n_i = ~wr;
		rd_n_i = wr;
		repeat (5) @(negedge clk_i);
		got_d = data_o;
		got_oe = data_oe_n_o;
		cs_n_i = 1'b1;
		wr_n_i = 1'b1;
		rd_n_i = 1'b1;
		repeat (5) @(negedge clk_i);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, oe);
		bus(1'b0, a, 8'h00);
		chk("read enables", oe, got_oe);
		chk("read data", e, got_d & ~oe);
	endtask
	task automatic pins(input logic [1:0] s, input logic z, o);
		chk("select pins", {6'h0, s}, {6'h0, sel_n});
		chk("motor pins", {6'h0, z, o}, {6'h0, m0, m1});
	endtask

	task automatic t_reset();
		rd(3'h2, 8'h00, 8'h00);
		chk("core reset", 8'h1, {7'h0, core_rst});
		pins(2'h2, 1'b1, 1'b1);
		chk("drq irq", 8'h3, {6'h0, drq_o, irq_o});
		chk("dma gate", 8'h3, {6'h0, drq_oe_n, irq_oe_n});
		chk("dack tc", 8'h2, {6'h0, dack_n_o, tc_o});
		rd(3'h3, 8'h00, 8'hfc);
	endtask
	task automatic t_two();
		bus(1'b1, 3'h2, 8'h1c);
		pins(2'h2, 1'b0, 1'b1);
		chk("core reset", 8'h0, {7'h0, core_rst});
		chk("dma gate", 8'h0, {6'h0, drq_oe_n, irq_oe_n});
		chk("dack tc", 8'h1, {6'h0, dack_n_o, tc_o});
		rd(3'h2, 8'h1c, 8'h00);
		bus(1'b1, 3'h2, 8'h2d);
		pins(2'h1, 1'b1, 1'b0);
		chk("drives", 8'h02, {4'h0, drive_on});
	endtask
	// clear then set the reset bit in two writes, well over 100 ns low
	task automatic t_soft();
		bus(1'b1, 3'h2, 8'h29);
		chk("core reset", 8'h1, {7'h0, core_rst});
		rd(3'h2, 8'h29, 8'h00);
		pins(2'h1, 1'b1, 1'b0);
		bus(1'b1, 3'h2, 8'h2d);
		chk("core reset", 8'h0, {7'h0, core_rst});
	endtask
	task automatic t_alt();
		bus(1'b1, 3'h2, 8'h04);
		alt_i = 1'b1;
		@(negedge clk_i);
		chk("dma gate", 8'h0, {6'h0, drq_oe_n, irq_oe_n});
		alt_i = 1'b0;
		@(negedge clk_i);
		chk("dma gate", 8'h3, {6'h0, drq_oe_n, irq_oe_n});
		// mid-run hardware reset while in alternate mode
		alt_i = 1'b1;
		rstn_i = 1'b0;
		@(negedge clk_i);
		chk("dma gate", 8'h0, {6'h0, drq_oe_n, irq_oe_n});
		pins(2'h3, 1'b1, 1'b1);
		rstn_i = 1'b1;
		alt_i = 1'b0;
		rd(3'h2, 8'h00, 8'h00);
	endtask
	task automatic t_four();
		four_i = 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = (i < 4) ? ((8'h10 << i) | 8'h0c | i[7:0]) :
				(8'h0c | i[7:0]);
			bus(1'b1, 3'h2, v);
			pins(v[1:0], ~v[4 + v[1:0]], 1'b0);
			chk("drives", 8'h01 << v[1:0], {4'h0, drive_on});
			chk("motors", {7'h0, v[4 + v[1:0]]} << v[1:0],
				{4'h0, motor_on});
		end
		four_i = 1'b0;
		en_i = 1'b0;
		@(negedge clk_i);
		@(negedge clk_i);
		pins(2'h3, 1'b1, 1'b1);
		en_i = 1'b1;
	endtask
	// exchanged drive two takes pin zero and motor bit 6
	task automatic t_exch();
		xch_i = 1'b1;
		bus(1'b1, 3'h2, 8'h4e);
		pins(2'h2, 1'b0, 1'b1);
		chk("drives", 8'h01, {4'h0, drive_on});
		xch_i = 1'b0;
	endtask
	task automatic t_tape();
		bus(1'b1, 3'h3, 8'hff);
		chk("tape number", 8'h3, {6'h0, tape_num});
		chk("tape selected", 8'h1, {7'h0, tape_sel});
		rd(3'h3, 8'h03, 8'hfc);
		tape_i = 1'b1;
		rd(3'h3, 8'h03, 8'h00);
		// drive 0 never counts as the tape drive
		bus(1'b1, 3'h3, 8'h00);
		bus(1'b1, 3'h2, 8'h0c);
		chk("tape selected", 8'h0, {7'h0, tape_sel});
	endtask

	initial begin
		#1 rstn_i = 1'b0;
		repeat (20) @(negedge clk_i);
		rstn_i = 1'b1;
		@(negedge clk_i);
		t_reset();
		t_two();
		t_soft();
		t_exch();
		t_alt();
		t_four();
		t_tape();
		tally_and_finish();
	end
endmodule
